/* rtl/prm_defs.svh */
`ifndef PRM_DEFS_SVH
`define PRM_DEFS_SVH

// clock rate
`define PRM_CLK_HZ 10000000
`define PRM_CLK_PER_US (`PRM_CLK_HZ / 1000000)

// carrier reset pulse length, least time
`define PRM_RST_PULSE_US 100
`define PRM_RST_PULSE_CYC (`PRM_RST_PULSE_US * `PRM_CLK_PER_US)

// suspend-imminent lead before a low-power state, least time
`define PRM_SUS_LEAD_US 20
`define PRM_SUS_LEAD_CYC (`PRM_SUS_LEAD_US * `PRM_CLK_PER_US)

// counter width, enough for the longest count
`define PRM_CNT_W 12

// synchroniser bit positions
`define PRM_SYNC_W 9
`define PRM_IX_PWR_BUTTON 0
`define PRM_IX_RSTBTN 1
`define PRM_IX_GOOD 2
`define PRM_IX_MAINLOW 3
`define PRM_IX_WAKE 4
`define PRM_IX_BATTERY_LOW_N 5
`define PRM_IX_LID 6
`define PRM_IX_SLEEP 7
`define PRM_IX_ESPI 8

// synchroniser reset value: every input at its idle level except supply-good, which resets low
`define PRM_SYNC_RST 9'h0f3

`endif

/* rtl/prm_pkg.sv */
package prm_pkg;

	// power state, one-hot
	typedef enum logic [4:0] {
		PRM_ST_OFF = 5'h01,
		PRM_ST_START = 5'h02,
		PRM_ST_RUN = 5'h04,
		PRM_ST_PREP = 5'h08,
		PRM_ST_S3 = 5'h10
	} prm_state_t;

	// requests from module power management
	typedef struct packed {
		logic suspend_ram;
		logic soft_off;
		logic sw_reset;
	} prm_pm_req_t;

	// events and levels reported to power management
	typedef struct packed {
		logic pwr_btn;
		logic sleep_btn;
		logic wake;
		logic lid_chg;
		logic lid_closed;
		logic power_fail;
	} prm_pm_evt_t;

endpackage

/* rtl/prm_power_reset_manager.sv */
`timescale 1ns/1ps
`include "prm_defs.svh"

// Operation
// - falling edge on power button registers a power button event
// - power button event wakes from soft-off or suspend; running, power management may power down
// - reset button edge-triggered: one reset per falling edge, never held while low
// - carrier reset on reset button, supply-good low, main rail low, watchdog timeout
// - carrier reset also on software request
// - supply-good high means power good; startup held off while low
// - watchdog-expired output signals a watchdog timeout, otherwise low
// - suspend-imminent driven low before low-power state; unused in eSPI mode
// - suspend-to-RAM output low while in suspend-to-RAM; does not start suspend
// - both soft-off outputs driven identically, low while in soft-off
// - pcie wake input accepted as a wake request
// - battery-low input made available as a power-fail indication
// - lid switch state reported to power management as a lid event source
// - sleep button presses reported to power management for sleep or wake

module prm_power_reset_manager (
	// clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// carrier inputs, asynchronous
	input wire logic power_button_n_in,
	input wire logic reset_button_n_in,
	input wire logic supply_good_in,
	input wire logic main_supply_low_in,
	input wire logic pcie_wake_n_in,
	input wire logic battery_low_n_in,
	input wire logic lid_n_in,
	input wire logic sleep_button_n_in,
	input wire logic espi_select_in,
	// module side, same clock
	input wire prm_pkg::prm_pm_req_t pm_req_in,
	input wire logic watchdog_timeout_in,
	input wire logic watchdog_clear_in,
	// carrier outputs
	output logic carrier_reset_n_out,
	output logic watchdog_expired_out,
	output logic suspend_imminent_n_out,
	output logic suspend_to_ram_n_out,
	output logic soft_off_a_n_out,
	output logic soft_off_b_n_out,
	// module side reports
	output prm_pkg::prm_pm_evt_t pm_evt_out,
	output prm_pkg::prm_state_t power_state_out
);

	localparam logic [`PRM_SYNC_W-1:0] SYNC_RST = `PRM_SYNC_RST;
	localparam logic [`PRM_CNT_W-1:0] RST_LAST = `PRM_CNT_W'(`PRM_RST_PULSE_CYC - 1);
	localparam logic [`PRM_CNT_W-1:0] LEAD_LAST = `PRM_CNT_W'(`PRM_SUS_LEAD_CYC - 1);

	logic [`PRM_SYNC_W-1:0] raw;
	logic [`PRM_SYNC_W-1:0] meta_r;
	logic [`PRM_SYNC_W-1:0] sync_r;
	logic [`PRM_SYNC_W-1:0] prev_r;
	logic [`PRM_SYNC_W-1:0] fall;
	logic [`PRM_SYNC_W-1:0] chg;

	prm_pkg::prm_state_t state_r;
	prm_pkg::prm_state_t state_nxt;
	logic to_ram_r;
	logic [`PRM_CNT_W-1:0] lead_cnt_r;
	logic lead_done;

	logic [`PRM_CNT_W-1:0] rst_cnt_r;
	logic rst_busy_r;
	logic rst_trig;
	logic rst_hold;
	logic power_bad;
	logic wake_req;

	// gather the pins in synchroniser order
	assign raw[`PRM_IX_PWR_BUTTON] = power_button_n_in;
	assign raw[`PRM_IX_RSTBTN] = reset_button_n_in;
	assign raw[`PRM_IX_GOOD] = supply_good_in;
	assign raw[`PRM_IX_MAINLOW] = main_supply_low_in;
	assign raw[`PRM_IX_WAKE] = pcie_wake_n_in;
	assign raw[`PRM_IX_BATTERY_LOW_N] = battery_low_n_in;
	assign raw[`PRM_IX_LID] = lid_n_in;
	assign raw[`PRM_IX_SLEEP] = sleep_button_n_in;
	assign raw[`PRM_IX_ESPI] = espi_select_in;

	// two-flop synchroniser plus a history stage for edges
	genvar gi;
	generate
		for (gi = 0; gi < `PRM_SYNC_W; gi = gi + 1) begin : g_sync
			always_ff @(posedge clock_in or negedge nrst_in) begin
				if (!nrst_in) begin
					meta_r[gi] <= SYNC_RST[gi];
					sync_r[gi] <= SYNC_RST[gi];
					prev_r[gi] <= SYNC_RST[gi];
				end else begin
					meta_r[gi] <= raw[gi];
					sync_r[gi] <= meta_r[gi];
					prev_r[gi] <= sync_r[gi];
				end
			end
			// edges look only at the settled stages, never the first flop
			assign fall[gi] = prev_r[gi] & ~sync_r[gi];
			assign chg[gi] = prev_r[gi] ^ sync_r[gi];
		end
	endgenerate

	// supply trouble: good dropped or main rail under its minimum
	assign power_bad = ~sync_r[`PRM_IX_GOOD] | sync_r[`PRM_IX_MAINLOW];

	// any wake source out of suspend-to-RAM
	assign wake_req = fall[`PRM_IX_PWR_BUTTON] | fall[`PRM_IX_SLEEP] | ~sync_r[`PRM_IX_WAKE];

	assign lead_done = (lead_cnt_r == LEAD_LAST);

	// next power state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			prm_pkg::PRM_ST_OFF: begin
				if (fall[`PRM_IX_PWR_BUTTON]) begin
					state_nxt = prm_pkg::PRM_ST_START;
				end
			end
			prm_pkg::PRM_ST_START: begin
				// carrier may still be loading its programmable parts
				if (!power_bad) begin
					state_nxt = prm_pkg::PRM_ST_RUN;
				end
			end
			prm_pkg::PRM_ST_RUN: begin
				if (power_bad) begin
					state_nxt = prm_pkg::PRM_ST_START;
				end else if (pm_req_in.soft_off || pm_req_in.suspend_ram) begin
					state_nxt = prm_pkg::PRM_ST_PREP;
				end
			end
			prm_pkg::PRM_ST_PREP: begin
				if (lead_done) begin
					state_nxt = to_ram_r ? prm_pkg::PRM_ST_S3 : prm_pkg::PRM_ST_OFF;
				end
			end
			prm_pkg::PRM_ST_S3: begin
				if (wake_req) begin
					state_nxt = prm_pkg::PRM_ST_START;
				end
			end
			default: begin
				state_nxt = prm_pkg::PRM_ST_OFF;
			end
		endcase
	end

	// power state register
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= prm_pkg::PRM_ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// target of a pending entry; soft-off wins over suspend-to-RAM
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			to_ram_r <= 1'b0;
		end else if (state_r == prm_pkg::PRM_ST_RUN) begin
			to_ram_r <= pm_req_in.suspend_ram & ~pm_req_in.soft_off;
		end
	end

	// lead time that suspend-imminent stands before the low-power state
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lead_cnt_r <= '0;
		end else if (state_r == prm_pkg::PRM_ST_PREP && !lead_done) begin
			lead_cnt_r <= lead_cnt_r + `PRM_CNT_W'(1);
		end else begin
			lead_cnt_r <= '0;
		end
	end

	// reset pulse sources while running; the button by edge only, so a stuck button gives one pulse
	assign rst_trig = (state_r == prm_pkg::PRM_ST_RUN) &
		(fall[`PRM_IX_RSTBTN] | watchdog_timeout_in | pm_req_in.sw_reset);

	// reset held while supply is bad or not running; next state keeps it in step with the state report
	assign rst_hold = power_bad | (state_nxt != prm_pkg::PRM_ST_RUN);

	// pulse stretcher, retriggered by a new source
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_cnt_r <= '0;
			rst_busy_r <= 1'b0;
		end else if (rst_trig) begin
			rst_cnt_r <= '0;
			rst_busy_r <= 1'b1;
		end else if (rst_busy_r) begin
			rst_cnt_r <= rst_cnt_r + `PRM_CNT_W'(1);
			rst_busy_r <= (rst_cnt_r != RST_LAST - `PRM_CNT_W'(1));
		end
	end

	// carrier reset output
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			carrier_reset_n_out <= 1'b0;
		end else begin
			carrier_reset_n_out <= ~(rst_hold | rst_trig | rst_busy_r);
		end
	end

	// watchdog flag; a timeout in the clear cycle still sets it
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			watchdog_expired_out <= 1'b0;
		end else if (watchdog_timeout_in) begin
			watchdog_expired_out <= 1'b1;
		end else if (watchdog_clear_in) begin
			watchdog_expired_out <= 1'b0;
		end
	end

	// suspend state outputs, from the next state so they track it without lag
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			suspend_imminent_n_out <= 1'b0;
			suspend_to_ram_n_out <= 1'b1;
			soft_off_a_n_out <= 1'b0;
			soft_off_b_n_out <= 1'b0;
		end else begin
			// held high in eSPI mode since no lpc device listens
			suspend_imminent_n_out <= sync_r[`PRM_IX_ESPI] |
				(state_nxt == prm_pkg::PRM_ST_RUN) | (state_nxt == prm_pkg::PRM_ST_START);
			suspend_to_ram_n_out <= (state_nxt != prm_pkg::PRM_ST_S3);
			soft_off_a_n_out <= (state_nxt != prm_pkg::PRM_ST_OFF);
			soft_off_b_n_out <= (state_nxt != prm_pkg::PRM_ST_OFF);
		end
	end

	// event pulses and levels for power management
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pm_evt_out <= '0;
		end else begin
			pm_evt_out.pwr_btn <= fall[`PRM_IX_PWR_BUTTON];
			pm_evt_out.sleep_btn <= fall[`PRM_IX_SLEEP];
			pm_evt_out.wake <= fall[`PRM_IX_WAKE];
			pm_evt_out.lid_chg <= chg[`PRM_IX_LID];
			pm_evt_out.lid_closed <= ~sync_r[`PRM_IX_LID];
			pm_evt_out.power_fail <= ~sync_r[`PRM_IX_BATTERY_LOW_N];
		end
	end

	// state report
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			power_state_out <= prm_pkg::PRM_ST_OFF;
		end else begin
			power_state_out <= state_nxt;
		end
	end

endmodule

/* verif/prm_carrier_model.sv */
`timescale 1ns/1ps
module prm_carrier_model (
	// control
	input wire logic clock_in,
	input wire logic mains_on_in,
	input wire logic suspend_to_ram_n_in,
	// to module
	output logic supply_good_out
);
	logic [2:0] ramp_r = 3'h0;
	// inverted suspend-to-ram switches the main rails; good ramps up, drops at once
	always @(posedge clock_in) begin
		ramp_r <= (mains_on_in && suspend_to_ram_n_in) ? {ramp_r[1:0], 1'b1} : 3'h0;
	end
	assign supply_good_out = ramp_r[2];
endmodule

/* verif/prm_monitor.sv */
`timescale 1ns/1ps
module prm_monitor (
	// clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// watched pins
	input wire logic power_button_n_in,
	input wire logic watchdog_timeout_in,
	input wire logic carrier_reset_n_out,
	input wire logic watchdog_expired_out,
	input wire logic suspend_to_ram_n_out,
	input wire logic soft_off_a_n_out,
	input wire logic soft_off_b_n_out,
	input wire prm_pkg::prm_pm_evt_t pm_evt_out,
	input wire prm_pkg::prm_state_t power_state_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	logic run;
	logic [10:0] low_r;
	logic [7:0] prep_r;
	assign run = power_state_out == prm_pkg::PRM_ST_RUN;
	// length of a carrier reset pulse while running
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) low_r <= 11'h000;
		else low_r <= (run && !carrier_reset_n_out) ? low_r + 11'h001 : 11'h000;
	end
	// length of the suspend lead
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) prep_r <= 8'h00;
		else prep_r <= (power_state_out == prm_pkg::PRM_ST_PREP) ? prep_r + 8'h01 : 8'h00;
	end
	sequence press_s;
		power_button_n_in [*3] ##1 !power_button_n_in;
	endsequence
	sequence lead_end_s;
		$past(power_state_out) == prm_pkg::PRM_ST_PREP && power_state_out != prm_pkg::PRM_ST_PREP;
	endsequence
	AST_PWR_EVT: assert property (press_s |-> ##[2:4] pm_evt_out.pwr_btn)
		else $error("power button event missing");
	AST_SOFT_EQ: assert property (soft_off_a_n_out == soft_off_b_n_out)
		else $error("soft-off outputs differ");
	AST_OFF_LVL: assert property (soft_off_a_n_out == (power_state_out != prm_pkg::PRM_ST_OFF))
		else $error("soft-off level wrong");
	AST_S3_LVL: assert property (suspend_to_ram_n_out == (power_state_out != prm_pkg::PRM_ST_S3))
		else $error("suspend-to-ram level wrong");
	AST_RST_SRC: assert property (carrier_reset_n_out |-> run)
		else $error("carrier reset released outside run");
	AST_RST_END: assert property (low_r <= 11'h3e8)
		else $error("carrier reset held too long");
	AST_WDOG_EXP: assert property (watchdog_timeout_in && run |=> watchdog_expired_out ##0 !carrier_reset_n_out [*8])
		else $error("watchdog timeout not signalled");
	AST_LEAD: assert property (lead_end_s |-> prep_r == 8'hc8)
		else $error("suspend lead length wrong");
endmodule
bind prm_power_reset_manager prm_monitor mon (.clock_in, .nrst_in, .power_button_n_in, .watchdog_timeout_in,
	.carrier_reset_n_out, .watchdog_expired_out, .suspend_to_ram_n_out, .soft_off_a_n_out, .soft_off_b_n_out,
	.pm_evt_out, .power_state_out);

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clock_in = 1'b0, nrst_in = 1'b0, power_button_n_in = 1'b1, reset_button_n_in = 1'b1, supply_good_in;
	logic main_supply_low_in = 1'b0, pcie_wake_n_in = 1'b1, battery_low_n_in = 1'b1, lid_n_in = 1'b1;
	logic sleep_button_n_in = 1'b1, espi_select_in = 1'b0, watchdog_timeout_in = 1'b0, watchdog_clear_in = 1'b0;
	logic mains = 1'b1, carrier_reset_n_out, watchdog_expired_out, suspend_imminent_n_out;
	logic suspend_to_ram_n_out, soft_off_a_n_out, soft_off_b_n_out;
	prm_pkg::prm_pm_req_t pm_req_in = 3'h0;
	prm_pkg::prm_pm_evt_t pm_evt_out;
	prm_pkg::prm_state_t power_state_out;
	logic [5:0] seen = 6'h00;
	logic [15:0] lf = 16'h5f7e;
	int err_total = 0;
	int tests_run = 0;
	prm_power_reset_manager uut (.clock_in, .nrst_in, .power_button_n_in, .reset_button_n_in, .supply_good_in,
		.main_supply_low_in, .pcie_wake_n_in, .battery_low_n_in, .lid_n_in, .sleep_button_n_in, .espi_select_in,
		.pm_req_in, .watchdog_timeout_in, .watchdog_clear_in, .carrier_reset_n_out, .watchdog_expired_out,
		.suspend_imminent_n_out, .suspend_to_ram_n_out, .soft_off_a_n_out, .soft_off_b_n_out, .pm_evt_out,
		.power_state_out);
	prm_carrier_model cb (.clock_in, .mains_on_in(mains), .suspend_to_ram_n_in(suspend_to_ram_n_out),
		.supply_good_out(supply_good_in));
	always #50 clock_in = !clock_in;
	// event pulses last one cycle, so keep them sticky
	always @(posedge clock_in) seen <= seen | pm_evt_out;
	function logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function logic exp_lvl(input logic pin_n);
		return !pin_n;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#10;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_st(input prm_pkg::prm_state_t e);
		tests_run++;
		if (power_state_out !== e) begin
			err_total++;
			$display("mismatch state expected %h seen %h", e, power_state_out);
		end
	endtask
	// bounded wait, a miss ends the run
	task automatic wait_st(input prm_pkg::prm_state_t e);
		for (int i = 0; i < 400 && power_state_out !== e; i++) cyc(1);
		chk_st(e);
		if (power_state_out !== e) test_done();
	endtask
	task automatic press_pwr();
		power_button_n_in = 1'b0;
		cyc(2);
		power_button_n_in = 1'b1;
	endtask
	initial begin
		cyc(4);
		nrst_in = 1'b1;
		chk_st(prm_pkg::PRM_ST_OFF);
		chk("soft_off_b", 1'b0, soft_off_b_n_out);
		cyc(4);
		press_pwr();
		wait_st(prm_pkg::PRM_ST_RUN);
		cyc(2);
		chk("carrier_reset", 1'b1, carrier_reset_n_out);
		chk("pwr_evt", 1'b1, seen[5]);
		watchdog_timeout_in = 1'b1;
		cyc(1);
		watchdog_timeout_in = 1'b0;
		chk("watchdog", 1'b1, watchdog_expired_out);
		chk("carrier_reset", 1'b0, carrier_reset_n_out);
		cyc(1000);
		chk("carrier_reset", 1'b1, carrier_reset_n_out);
		watchdog_clear_in = 1'b1;
		cyc(1);
		watchdog_clear_in = 1'b0;
		chk("watchdog", 1'b0, watchdog_expired_out);
		// button held far past the pulse: one pulse only
		reset_button_n_in = 1'b0;
		cyc(6);
		chk("carrier_reset", 1'b0, carrier_reset_n_out);
		cyc(1100);
		chk("carrier_reset", 1'b1, carrier_reset_n_out);
		reset_button_n_in = 1'b1;
		pm_req_in.sw_reset = 1'b1;
		cyc(1);
		pm_req_in = 3'h0;
		cyc(2);
		chk("carrier_reset", 1'b0, carrier_reset_n_out);
		cyc(1000);
		// main rail under its minimum drops the system back to start
		main_supply_low_in = 1'b1;
		cyc(4);
		chk_st(prm_pkg::PRM_ST_START);
		chk("carrier_reset", 1'b0, carrier_reset_n_out);
		main_supply_low_in = 1'b0;
		wait_st(prm_pkg::PRM_ST_RUN);
		cyc(1);
		chk("carrier_reset", 1'b1, carrier_reset_n_out);
		repeat (40) begin
			lf = lfsr(lf);
			battery_low_n_in = lf[0];
			lid_n_in = lf[1];
			cyc(5);
			chk("power_fail", exp_lvl(battery_low_n_in), pm_evt_out.power_fail);
			chk("lid_closed", exp_lvl(lid_n_in), pm_evt_out.lid_closed);
		end
		chk("lid_evt", 1'b1, seen[2]);
		battery_low_n_in = 1'b1;
		lid_n_in = 1'b1;
		sleep_button_n_in = 1'b0;
		cyc(6);
		sleep_button_n_in = 1'b1;
		chk("sleep_evt", 1'b1, seen[4]);
		pm_req_in.suspend_ram = 1'b1;
		cyc(1);
		pm_req_in = 3'h0;
		cyc(1);
		chk("imminent", 1'b0, suspend_imminent_n_out);
		wait_st(prm_pkg::PRM_ST_S3);
		chk("s3", 1'b0, suspend_to_ram_n_out);
		cyc(10);
		pcie_wake_n_in = 1'b0;
		cyc(6);
		pcie_wake_n_in = 1'b1;
		wait_st(prm_pkg::PRM_ST_RUN);
		chk("wake_evt", 1'b1, seen[3]);
		pm_req_in.soft_off = 1'b1;
		cyc(1);
		pm_req_in = 3'h0;
		wait_st(prm_pkg::PRM_ST_OFF);
		chk("soft_off_a", 1'b0, soft_off_a_n_out);
		// in eSPI mode the imminent output stays high
		espi_select_in = 1'b1;
		press_pwr();
		wait_st(prm_pkg::PRM_ST_RUN);
		pm_req_in.suspend_ram = 1'b1;
		cyc(1);
		pm_req_in = 3'h0;
		cyc(2);
		chk("imminent", 1'b1, suspend_imminent_n_out);
		wait_st(prm_pkg::PRM_ST_S3);
		press_pwr();
		wait_st(prm_pkg::PRM_ST_RUN);
		mains = 1'b0;
		cyc(8);
		chk_st(prm_pkg::PRM_ST_START);
		chk("carrier_reset", 1'b0, carrier_reset_n_out);
		// timeout and clear in one cycle: the timeout wins
		watchdog_timeout_in = 1'b1;
		watchdog_clear_in = 1'b1;
		cyc(1);
		watchdog_timeout_in = 1'b0;
		watchdog_clear_in = 1'b0;
		chk("watchdog", 1'b1, watchdog_expired_out);
		watchdog_clear_in = 1'b1;
		cyc(1);
		watchdog_clear_in = 1'b0;
		chk("watchdog", 1'b0, watchdog_expired_out);
		test_done();
	end
endmodule
